// [tp_pkg.sv]
package tp_pkg;
	// register byte addresses
	localparam logic [11:0] TP_OFS_CTRL = 12'h02C;
	localparam logic [11:0] TP_OFS_MODE0 = 12'h030;
	localparam logic [11:0] TP_OFS_MODE1 = 12'h034;
	localparam logic [11:0] TP_OFS_CMP0 = 12'h038;
	localparam logic [11:0] TP_OFS_CMP1 = 12'h03C;
	localparam logic [11:0] TP_OFS_COUNT = 12'h040;
	localparam logic [11:0] TP_OFS_STAT = 12'h044;
	localparam logic [11:0] TP_OFS_PGATE = 12'hF74;

	// timer_pair_control fields
	localparam int TP_CTRL_FIRST_RUN = 0;
	localparam int TP_CTRL_SECOND_RUN = 1;
	localparam int TP_CTRL_CASCADE = 2;
	localparam int TP_CTRL_COMBINE = 3;
	localparam logic [3:0] TP_CTRL_RST = 4'h0;

	// per-timer mode register fields
	localparam int TP_MODE_OP_LSB = 0;
	localparam int TP_MODE_EXT = 2;
	localparam int TP_MODE_CK_LSB = 3;
	localparam logic [5:0] TP_MODE_RST = 6'h00;
	localparam logic [7:0] TP_CMP_RST = 8'hFF;

	// power_gate_register fields
	localparam int TP_PGATE_EN = 4;
	localparam logic TP_PGATE_RST = 1'b0;

	// clock select codes usable on the low-frequency clock
	localparam logic [2:0] TP_CK_FS16 = 3'h0;
	localparam logic [2:0] TP_CK_FS8 = 3'h1;
	localparam logic [2:0] TP_CK_FS4 = 3'h7;

	// divider exponents of the gear clock per select code
	localparam int TP_GEAR_W = 11;
	localparam int TP_GEAR_EXP [0:7] = '{11, 10, 8, 6, 4, 2, 1, 0};
	localparam int TP_FS_W = 4;

	typedef enum logic [1:0] {
		TP_OP_TIMER,
		TP_OP_TIMER_ALT,
		TP_OP_PWM,
		TP_OP_PPG
	} tp_op_e;
endpackage

// [tp_src_if.sv]
`timescale 1ns/100ps
interface tp_src_if;
	logic [7:0] gear_tick;
	logic [2:0] fs_tick;
	logic fs_ok;
	logic [1:0] ext_fall;
	modport pre(output gear_tick, output fs_tick, output fs_ok);
	modport edg(output ext_fall);
	modport core(input gear_tick, input fs_tick, input fs_ok,
		input ext_fall);
endinterface

// [tp_prescale.sv]
`timescale 1ns/100ps
module tp_prescale
	import tp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic gate_en,
	input wire logic fs_clk_pin,
	input wire logic fs_running,
	tp_src_if.pre src
);
	logic [TP_GEAR_W-1:0] gear_q;
	logic [TP_FS_W-1:0] fs_cnt_q;
	logic fs_m_q, fs_s_q, fs_d_q, ok_m_q, ok_s_q;
	logic fs_rise;

	function automatic logic [TP_GEAR_W-1:0] low_mask(input int e);
		logic [TP_GEAR_W:0] m;
		m = (TP_GEAR_W+1)'((1 << e) - 1);
		return m[TP_GEAR_W-1:0];
	endfunction

	// gear divider stops with the gate so nothing ticks while cut
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			gear_q <= '0;
		else if (!gate_en)
			gear_q <= '0;
		else
			gear_q <= gear_q + 1'b1;
	end

	// low-frequency clock and its run flag come in asynchronously
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{fs_m_q, fs_s_q, fs_d_q} <= 3'h0;
			{ok_m_q, ok_s_q} <= 2'h0;
		end else begin
			{fs_m_q, fs_s_q, fs_d_q} <= {fs_clk_pin, fs_m_q, fs_s_q};
			{ok_m_q, ok_s_q} <= {fs_running, ok_m_q};
		end
	end
	assign fs_rise = fs_s_q & ~fs_d_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			fs_cnt_q <= '0;
		else if (!gate_en)
			fs_cnt_q <= '0;
		else if (fs_rise)
			fs_cnt_q <= fs_cnt_q + 1'b1;
	end

	// one-cycle ticks for each gear division code
	always_comb begin
		for (int k = 0; k < 8; k++)
			src.gear_tick[k] = gate_en &&
				((gear_q & low_mask(TP_GEAR_EXP[k])) ==
				low_mask(TP_GEAR_EXP[k]));
	end

	// a stalled low-frequency oscillator yields no ticks at all
	assign src.fs_ok = ok_s_q;
	assign src.fs_tick[0] = gate_en & ok_s_q & fs_rise & (&fs_cnt_q[1:0]);
	assign src.fs_tick[1] = gate_en & ok_s_q & fs_rise & (&fs_cnt_q[2:0]);
	assign src.fs_tick[2] = gate_en & ok_s_q & fs_rise & (&fs_cnt_q);
endmodule

// [tp_edge.sv]
`timescale 1ns/100ps
module tp_edge
	import tp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] event_pin,
	tp_src_if.edg src
);
	logic [1:0] meta_q, sync_q, last_q;

	// two stages before anyone looks, third stage only for the edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
			last_q <= 2'h3;
		end else begin
			meta_q <= event_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// falling edges count as events
	assign src.ext_fall = last_q & ~sync_q;
endmodule

// [tp_timer_pair.sv]
// Contract
// - run bit 0 stops and clears; 1 starts
// - cascade bit joins timers into 16 bits
// - no combine: each timer drives own pins
// - combine: second pins carry AND of both
// - combine: first pins held high
// - stop mode clears both run bits
// - control register upper four bits read zero
// - combine and cascade locked while running
// - starting both may also set them
// - clock select codes map to dividers
// - modes use only their legal sources
// - cascade takes second timer's clock select
// - stalled low-frequency clock gives no ticks
// - low-speed mode allows codes 000,001,111 only
// - cascade takes event from first pin
// - power gate off cuts timer clock
// - eight operating modes, four per width; only timer counting is modelled
// - external select counts pin falling edges
// - cascade ignores first run bit
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module tp_timer_pair
	import tp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_event_pin,
	input wire logic second_event_pin,
	input wire logic fs_clk_pin,
	input wire logic fs_running,
	input wire logic low_speed_mode,
	input wire logic fs_div_select,
	input wire logic stop_mode_enter,
	output logic first_pulse_out,
	output logic first_pattern_out,
	output logic second_pulse_out,
	output logic second_pattern_out
);
	tp_src_if src();

	logic [1:0] run_q;
	logic cas_q, comb_q, pgate_q;
	logic [5:0] mode0_q, mode1_q;
	logic [7:0] cmp0_q, cmp1_q, cnt0_q, cnt1_q;
	logic t0_q, t1_q, out0_q, out1_q;
	logic [31:0] prdata_q;
	logic wr, rd_setup, tick0, tick1, act0, act_cas, act1;
	logic [15:0] next16;

	function automatic logic addr_ok(input logic [11:0] a);
		if (a == TP_OFS_CTRL || a == TP_OFS_MODE0 || a == TP_OFS_MODE1)
			return 1'b1;
		else if (a == TP_OFS_CMP0 || a == TP_OFS_CMP1)
			return 1'b1;
		else if (a == TP_OFS_COUNT || a == TP_OFS_STAT)
			return 1'b1;
		else if (a == TP_OFS_PGATE)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	// match clears to zero, otherwise count up
	function automatic logic [15:0] count_next(input logic [15:0] c,
		input logic [15:0] m);
		return (c == m) ? 16'h0000 : c + 16'h0001;
	endfunction

	// source tick for one timer from its mode field
	function automatic logic pick_tick(input logic [5:0] mode,
		input logic fall, input logic slow, input logic fs_sel,
		input logic [7:0] gt, input logic [2:0] ft);
		logic [2:0] ck;
		logic t;
		ck = mode[TP_MODE_CK_LSB+:3];
		t = 1'b0;
		if (mode[TP_MODE_EXT])
			t = fall;
		else if (slow) begin
			// low-speed: only three codes have a clock
			if (ck == TP_CK_FS16)
				t = ft[2];
			else if (ck == TP_CK_FS8)
				t = ft[1];
			else if (ck == TP_CK_FS4)
				t = ft[0];
			else
				t = 1'b0;
		end else if (fs_sel && ck == TP_CK_FS16)
			t = ft[2];
		else if (fs_sel && ck == TP_CK_FS8)
			t = ft[1];
		else
			t = gt[ck];
		return t;
	endfunction

	tp_prescale u_pre (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.gate_en(pgate_q),
		.fs_clk_pin(fs_clk_pin),
		.fs_running(fs_running),
		.src(src)
	);

	tp_edge u_edge (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.event_pin({second_event_pin, first_event_pin}),
		.src(src)
	);

	// zero-wait slave: access phase always completes at once
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok(paddr);
	assign prdata = prdata_q;

	// control register; stop mode outranks a same-cycle write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			run_q <= TP_CTRL_RST[1:0];
			cas_q <= TP_CTRL_RST[TP_CTRL_CASCADE];
			comb_q <= TP_CTRL_RST[TP_CTRL_COMBINE];
		end else if (stop_mode_enter) begin
			run_q <= 2'h0;
		end else if (wr && paddr == TP_OFS_CTRL) begin
			run_q <= {pwdata[TP_CTRL_SECOND_RUN],
				pwdata[TP_CTRL_FIRST_RUN]};
			// old run state decides, so a start may carry them
			if (run_q == 2'h0) begin
				cas_q <= pwdata[TP_CTRL_CASCADE];
				comb_q <= pwdata[TP_CTRL_COMBINE];
			end
		end
	end

	// mode, compare and gate registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode0_q <= TP_MODE_RST;
			mode1_q <= TP_MODE_RST;
			cmp0_q <= TP_CMP_RST;
			cmp1_q <= TP_CMP_RST;
			pgate_q <= TP_PGATE_RST;
		end else if (wr) begin
			// mode changes would corrupt a running count
			if (paddr == TP_OFS_MODE0 && run_q == 2'h0)
				mode0_q <= pwdata[5:0];
			else if (paddr == TP_OFS_MODE1 && run_q == 2'h0)
				mode1_q <= pwdata[5:0];
			else if (paddr == TP_OFS_CMP0)
				cmp0_q <= pwdata[7:0];
			else if (paddr == TP_OFS_CMP1)
				cmp1_q <= pwdata[7:0];
			else if (paddr == TP_OFS_PGATE)
				pgate_q <= pwdata[TP_PGATE_EN];
		end
	end

	// read data is latched in the setup phase
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup) begin
			if (paddr == TP_OFS_CTRL)
				prdata_q <= {28'h0, comb_q, cas_q, run_q};
			else if (paddr == TP_OFS_MODE0)
				prdata_q <= {26'h0, mode0_q};
			else if (paddr == TP_OFS_MODE1)
				prdata_q <= {26'h0, mode1_q};
			else if (paddr == TP_OFS_CMP0)
				prdata_q <= {24'h0, cmp0_q};
			else if (paddr == TP_OFS_CMP1)
				prdata_q <= {24'h0, cmp1_q};
			else if (paddr == TP_OFS_COUNT)
				prdata_q <= {16'h0, cnt1_q, cnt0_q};
			else if (paddr == TP_OFS_STAT)
				prdata_q <= {26'h0, low_speed_mode, src.fs_ok,
					t1_q, t0_q, act1 | act_cas, act0};
			else if (paddr == TP_OFS_PGATE)
				prdata_q <= {27'h0, pgate_q, 4'h0};
			else
				prdata_q <= 32'h0000_0000;
		end
	end

	// who runs: cascade follows only the second run bit
	assign act0 = run_q[0] & ~cas_q;
	assign act1 = run_q[1] & ~cas_q;
	assign act_cas = run_q[1] & cas_q;

	// gate low means no tick reaches either counter
	assign tick0 = pgate_q & pick_tick(mode0_q, src.ext_fall[0],
		low_speed_mode, fs_div_select, src.gear_tick, src.fs_tick);
	// cascade: second clock select, first event pin
	assign tick1 = pgate_q & pick_tick(mode1_q,
		cas_q ? src.ext_fall[0] : src.ext_fall[1],
		low_speed_mode, fs_div_select, src.gear_tick, src.fs_tick);
	assign next16 = count_next({cnt1_q, cnt0_q}, {cmp1_q, cmp0_q});

	// counters and their output flip-flops; only timer-style counting
	// is modelled, the mode field is kept for software
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt0_q <= 8'h00;
			cnt1_q <= 8'h00;
			t0_q <= 1'b0;
			t1_q <= 1'b0;
		end else if (cas_q) begin
			if (!act_cas) begin
				cnt0_q <= 8'h00;
				cnt1_q <= 8'h00;
			end else if (tick1) begin
				{cnt1_q, cnt0_q} <= next16;
				if ({cnt1_q, cnt0_q} == {cmp1_q, cmp0_q})
					t1_q <= ~t1_q;
			end
		end else begin
			if (!act0)
				cnt0_q <= 8'h00;
			else if (tick0) begin
				cnt0_q <= 8'(count_next({8'h00, cnt0_q},
					{8'h00, cmp0_q}));
				if (cnt0_q == cmp0_q)
					t0_q <= ~t0_q;
			end
			if (!act1)
				cnt1_q <= 8'h00;
			else if (tick1) begin
				cnt1_q <= 8'(count_next({8'h00, cnt1_q},
					{8'h00, cmp1_q}));
				if (cnt1_q == cmp1_q)
					t1_q <= ~t1_q;
			end
		end
	end

	// pin routing, registered so the pins never glitch
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			out0_q <= 1'b0;
			out1_q <= 1'b0;
		end else if (comb_q) begin
			out0_q <= 1'b1;
			out1_q <= t0_q & t1_q;
		end else begin
			out0_q <= t0_q;
			out1_q <= t1_q;
		end
	end
	assign first_pulse_out = out0_q;
	assign first_pattern_out = out0_q;
	assign second_pulse_out = out1_q;
	assign second_pattern_out = out1_q;

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_stop_clears_run: assert property (
		stop_mode_enter |=> run_q == 2'h0)
		else $error("run bits survive stop mode");
	a_upper_read_zero: assert property (
		rd_setup && paddr == TP_OFS_CTRL |=> prdata[7:4] == 4'h0)
		else $error("control upper bits not zero");
	a_cfg_locked: assert property (
		wr && paddr == TP_OFS_CTRL && run_q != 2'h0
		|=> $stable(cas_q) && $stable(comb_q))
		else $error("cascade or combine changed while running");
	a_cfg_at_start: assert property (
		wr && paddr == TP_OFS_CTRL && run_q == 2'h0 && !stop_mode_enter
		|=> cas_q == $past(pwdata[TP_CTRL_CASCADE]) &&
		comb_q == $past(pwdata[TP_CTRL_COMBINE]))
		else $error("cascade or combine not taken at start");
	a_stop_clears_cnt: assert property (
		!cas_q && !run_q[0] ##1 !cas_q && !run_q[0] |-> cnt0_q == 8'h00)
		else $error("stopped first counter not cleared");
	a_casc_first_run: assert property (
		cas_q && !run_q[1] |=> {cnt1_q, cnt0_q} == 16'h0000)
		else $error("cascade counted without second run bit");
	a_combine_route: assert property (
		comb_q |=> second_pulse_out == ($past(t0_q) & $past(t1_q)))
		else $error("second pins not the AND of both timers");
	a_first_high: assert property (
		comb_q ##1 comb_q |-> first_pulse_out && first_pattern_out)
		else $error("first pins not high while combined");
	a_plain_route: assert property (
		!comb_q |=> first_pulse_out == $past(t0_q) &&
		second_pulse_out == $past(t1_q))
		else $error("timer outputs misrouted");
	a_gate_freezes: assert property (
		!pgate_q && !comb_q ##1 !pgate_q |-> $stable(t0_q) && $stable(t1_q))
		else $error("timer output moved with gate off");

	c_cascade_match: cover property (act_cas && tick1 &&
		{cnt1_q, cnt0_q} == {cmp1_q, cmp0_q});
	c_first_match: cover property (act0 && tick0 && cnt0_q == cmp0_q);
	c_locked_write: cover property (wr && paddr == TP_OFS_CTRL &&
		run_q != 2'h0);
	c_stop_while_run: cover property (stop_mode_enter && run_q != 2'h0);
endmodule

// [tp_far_model.sv]
`timescale 1ns/100ps
// far side of the pair: low-frequency oscillator and both event pins
module tp_far_model(
	input wire logic clk_sys,
	input wire logic fs_on,
	output logic fs_clk_pin,
	output logic fs_running,
	output logic first_event_pin,
	output logic second_event_pin
);
	logic [1:0] div;

	initial begin
		div = 2'h0;
		fs_clk_pin = 1'b0;
		fs_running = 1'b0;
		first_event_pin = 1'b1;
		second_event_pin = 1'b1;
	end

	// oscillator at clk/8; the pin wobbles even while the running flag
	// is low, so only that flag can keep fs ticks out
	always @(posedge clk_sys) begin
		div <= div + 2'h1;
		fs_running <= fs_on;
		if (div == 2'h3)
			fs_clk_pin <= ~fs_clk_pin;
	end

	// n falling edges on one pin, levels held four cycles so that
	// the synchroniser cannot miss one
	task automatic ev(input logic s, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			{second_event_pin, first_event_pin} <= s ? 2'b01 : 2'b10;
			repeat (4) @(posedge clk_sys);
			{second_event_pin, first_event_pin} <= 2'b11;
			repeat (3) @(posedge clk_sys);
		end
	endtask
endmodule

// [test_tp_timer_pair.sv]
`timescale 1ns/100ps
module test_tp_timer_pair;
	import tp_pkg::*;
	logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic low_speed_mode, fs_div_select, stop_mode_enter, fs_on;
	logic fs_clk_pin, fs_running, first_event_pin, second_event_pin;
	logic first_pulse_out, first_pattern_out;
	logic second_pulse_out, second_pattern_out;
	logic [3:0] pins;
	int errors = 0;
	int n_tests = 0;
	int n;
	int gexp [8] = '{11, 10, 8, 6, 4, 2, 1, 0};

	tp_timer_pair dut(.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .first_event_pin,
		.second_event_pin, .fs_clk_pin, .fs_running, .low_speed_mode,
		.fs_div_select, .stop_mode_enter, .first_pulse_out,
		.first_pattern_out, .second_pulse_out, .second_pattern_out);
	tp_far_model far(.clk_sys, .fs_on, .fs_clk_pin, .fs_running,
		.first_event_pin, .second_event_pin);

	assign pins = {second_pattern_out, second_pulse_out,
		first_pattern_out, first_pulse_out};

	always #50 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one APB transfer; request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] ex);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), ex, rdat);
	endtask

	// cycles between two toggles; the first toggle only aligns us,
	// since the prescaler phase at start is unknown
	task automatic gap(input logic s, output int m);
		logic v;
		repeat (2) begin
			v = s ? second_pulse_out : first_pulse_out;
			m = 0;
			while ((s ? second_pulse_out : first_pulse_out) === v
				&& m < 5000) begin
				@(posedge clk_sys);
				m++;
			end
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, about four times the expected run length
	initial begin
		repeat (30000) @(posedge clk_sys);
		errors++;
		end_of_test;
	end

	initial begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		low_speed_mode = 1'b0;
		fs_div_select = 1'b0;
		stop_mode_enter = 1'b0;
		fs_on = 1'b0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		rc(TP_OFS_CTRL, 32'h0);
		rc(TP_OFS_PGATE, 32'h0);
		// gate on before any timer register is touched
		wr(TP_OFS_PGATE, 32'hFF);
		rc(TP_OFS_PGATE, 32'h10);
		xfer(1'b0, 12'h100, 32'h0);
		chk("slverr", 32'h1, {31'h0, rerr});
		chk("unmapped", 32'h0, rdat);
		wr(TP_OFS_CTRL, 32'hFF);
		rc(TP_OFS_CTRL, 32'h0F);
		wr(TP_OFS_CTRL, 32'h00);
		rc(TP_OFS_CTRL, 32'h0C);
		wr(TP_OFS_CTRL, 32'h00);
		rc(TP_OFS_CTRL, 32'h00);
		// every gear code with compare 0: one toggle per source tick
		wr(TP_OFS_CMP0, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(TP_OFS_MODE0, 32'(c << 3));
			wr(TP_OFS_CTRL, 32'h1);
			gap(1'b0, n);
			chk("gear gap", 32'(1 << gexp[c]), 32'(n));
			wr(TP_OFS_CTRL, 32'h0);
		end
		wr(TP_OFS_CMP0, 32'h2);
		wr(TP_OFS_CTRL, 32'h1);
		gap(1'b0, n);
		chk("walk gap", 32'h3, 32'(n));
		@(posedge clk_sys);
		stop_mode_enter <= 1'b1;
		@(posedge clk_sys);
		stop_mode_enter <= 1'b0;
		rc(TP_OFS_CTRL, 32'h0);
		rc(TP_OFS_COUNT, 32'h0);
		// gate cut only while stopped; a start must then not count
		wr(TP_OFS_CMP0, 32'hFF);
		wr(TP_OFS_PGATE, 32'h0);
		wr(TP_OFS_CTRL, 32'h1);
		repeat (20) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h0);
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_PGATE, 32'h10);
		// combine on: first pins high, second pins the AND
		wr(TP_OFS_MODE1, 32'h38);
		wr(TP_OFS_CMP0, 32'h0);
		wr(TP_OFS_CMP1, 32'h1);
		wr(TP_OFS_CTRL, 32'h0B);
		repeat (2) @(posedge clk_sys);
		repeat (8) begin
			@(posedge clk_sys);
			chk("first pins", 32'h3, {30'h0, pins[1:0]});
		end
		wr(TP_OFS_CTRL, 32'h0);
		rc(TP_OFS_CTRL, 32'h08);
		xfer(1'b0, TP_OFS_STAT, 32'h0);
		chk("and", {30'h0, {2{rdat[2] & rdat[3]}}}, {30'h0, pins[3:2]});
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_CTRL, 32'h3);
		repeat (5) @(posedge clk_sys);
		wr(TP_OFS_CTRL, 32'h0);
		xfer(1'b0, TP_OFS_STAT, 32'h0);
		chk("pins", {28'h0, {2{rdat[3]}}, {2{rdat[2]}}}, {28'h0, pins});
		// cascade: first run alone must not start the pair
		wr(TP_OFS_MODE0, 32'h0);
		wr(TP_OFS_CMP0, 32'h1);
		wr(TP_OFS_CMP1, 32'h0);
		wr(TP_OFS_CTRL, 32'h5);
		repeat (20) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h0);
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_CTRL, 32'h6);
		gap(1'b1, n);
		chk("cascade gap", 32'h2, 32'(n));
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_MODE1, 32'h04);
		wr(TP_OFS_CMP0, 32'hFF);
		wr(TP_OFS_CMP1, 32'hFF);
		wr(TP_OFS_CTRL, 32'h6);
		far.ev(1'b1, 2);
		far.ev(1'b0, 3);
		repeat (6) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h3);
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_MODE0, 32'h04);
		wr(TP_OFS_CTRL, 32'h3);
		far.ev(1'b0, 2);
		far.ev(1'b1, 1);
		repeat (6) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h0102);
		wr(TP_OFS_CTRL, 32'h0);
		// low-frequency sources: fs/8 in normal mode, fs/4 in low speed
		fs_on <= 1'b1;
		fs_div_select <= 1'b1;
		wr(TP_OFS_MODE0, 32'h08);
		wr(TP_OFS_CMP0, 32'h0);
		wr(TP_OFS_CTRL, 32'h1);
		gap(1'b0, n);
		chk("fs8 gap", 32'd64, 32'(n));
		wr(TP_OFS_CTRL, 32'h0);
		fs_div_select <= 1'b0;
		low_speed_mode <= 1'b1;
		wr(TP_OFS_MODE0, 32'h38);
		wr(TP_OFS_CTRL, 32'h1);
		gap(1'b0, n);
		chk("fs4 gap", 32'd32, 32'(n));
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_MODE0, 32'h00);
		wr(TP_OFS_CTRL, 32'h1);
		gap(1'b0, n);
		chk("fs16 gap", 32'd128, 32'(n));
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_MODE0, 32'h10);
		wr(TP_OFS_CMP0, 32'hFF);
		wr(TP_OFS_CTRL, 32'h1);
		repeat (200) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h0);
		wr(TP_OFS_CTRL, 32'h0);
		wr(TP_OFS_MODE0, 32'h38);
		fs_on <= 1'b0;
		wr(TP_OFS_CTRL, 32'h1);
		repeat (200) @(posedge clk_sys);
		rc(TP_OFS_COUNT, 32'h0);
		end_of_test;
	end
endmodule
